// ---- flow_pulse_regs.svh ----
// Constants of the flow pulse output control: switch code limit, pole pairs, timing, reset direction.
// Assumes a 40 MHz system clock and a pole wheel of 26 pole pairs.
`ifndef FLOW_PULSE_REGS_SVH
`define FLOW_PULSE_REGS_SVH

// Clock period in picoseconds (25 ns).
`define CLK_PERIOD_PS 32'd25000
// Blink half period in milliseconds, giving about 2 Hz.
`define BLINK_HALF_MS 32'd250
// Blink half period in clock cycles; scaled through nanoseconds so the product fits 32 bits.
`define BLINK_HALF_CYC ((`BLINK_HALF_MS * 32'd1000000) / (`CLK_PERIOD_PS / 32'd1000))
// Pole pairs of the scanned wheel.
`define POLE_PAIRS 32'd26
// Highest switch code that selects a factor.
`define FACTOR_LAST_CODE 4'h9
// Reset value of the stored preferred direction (forward).
`define PREF_DIR_RESET 1'b1

`endif

// ---- flow_pulse_pkg.sv ----
// Types of the flow pulse output control.
// Assumes nothing beyond the constants header.
package flow_pulse_pkg;
    // Output sequencer states, one-hot.
    typedef enum logic [2:0] {
        OUT_IDLE  = 3'b001,
        OUT_STEP  = 3'b010,
        OUT_GAP   = 3'b100
    } out_state_t;
endpackage

// ---- quad_phase_gen.sv ----
// Quadrature phase generator: one step per request moves A/B a quarter period.
// Assumes requests come from logic on the same clock.
`timescale 1ns/1ps
module quad_phase_gen (
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic stepReq,
    input  wire logic stepFwd,
    output logic      phaseA,
    output logic      phaseB
);
    // Gray count of the quadrature position.
    logic [1:0] pos_reg;
    logic [1:0] pos_next;

    // Forward walks 00,01,11,10 so B trails A by a quarter period.
    assign pos_next = stepFwd ? {pos_reg[0], ~pos_reg[1]} : {~pos_reg[0], pos_reg[1]};

    // The position advances one quarter only on a step request.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pos_reg <= 2'h0;
        end else if (stepReq) begin
            pos_reg <= pos_next;
        end
    end

    // Outputs come straight from the position flip-flops.
    assign phaseA = pos_reg[0];
    assign phaseB = pos_reg[1];
endmodule

// ---- flow_pulse_output_control.sv ----
// Flow pulse output control: filters oscillation, emits quadrature and lamps.
// Assumes rotor edge pulses and switches arrive from outside the clock domain.
// Summary of operation
// - Filter only when jumper enables it.
// - Net forward/backward edges while within half turn.
// - Release net pulses once half turn exceeded.
// - Store released burst direction as preferred.
// - Reverse switch swaps phases, inverts direction.
// - Codes 0-9 pick factors; A-F none, flashing.
// - New factor takes effect immediately.
// - Normal: green on, yellow and red off.
// - Configuration needed: all lamps on, no output.
// - Pickup or interpolator fault lights red.
// - Flow overload lights red.
// - Component defect: all flash, output off forever.
// - Red lamp only for measurement-affecting events.
// - Channel B lags A by quarter period.
// - Direction high positive, low negative.
// - Half turn is 26 pole pairs times factor.
`timescale 1ns/1ps
`include "flow_pulse_regs.svh"
module flow_pulse_output_control #(
    parameter int BAL_W    = 16,              // Width of the signed edge balance.
    parameter int BLINK_CYC = `BLINK_HALF_CYC  // Blink half period in cycles.
) (
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic       edgeFwd,
    input  wire logic       edgeBwd,
    input  wire logic [3:0] factor_select_switch,
    input  wire logic       direction_swap_switch,
    input  wire logic       filter_enable_jumper,
    input  wire logic       configNeeded,
    input  wire logic       pickupFault,
    input  wire logic       flowOverload,
    input  wire logic       componentDefect,
    output logic            channelA,
    output logic            channelB,
    output logic            channelEnable,
    output logic            flow_sense_output,
    output logic            preferredDir,
    output logic [7:0]      pulse_multiplier_setting,
    output logic            pulse_active_lamp,
    output logic            lampYellow,
    output logic            lampRed
);
    // Maps a switch code to its interpolation factor, zero for no factor.
    function automatic logic [7:0] factor_of(input logic [3:0] code);
        logic [7:0] f;
        f = 8'h00;
        case (code)
            4'h0: f = 8'h01;
            4'h1: f = 8'h02;
            4'h2: f = 8'h05;
            4'h3: f = 8'h0A;
            4'h4: f = 8'h19;
            4'h5: f = 8'h20;
            4'h6: f = 8'h32;
            4'h7: f = 8'h40;
            4'h8: f = 8'h64;
            4'h9: f = 8'h80;
            default: f = 8'h00;
        endcase
        return f;
    endfunction

    // Two-stage synchronisers for every pin input.
    logic [10:0] syncA_reg;   // First stages, read only by the second.
    logic [10:0] syncB_reg;   // Second stages, used by the logic.
    logic        fwdPrev_reg; // Previous synchronised forward edge level.
    logic        bwdPrev_reg; // Previous synchronised backward edge level.

    // Both stages clear on reset and then follow the pins.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            syncA_reg <= 11'h000;
            syncB_reg <= 11'h000;
        end else begin
            syncA_reg <= {edgeFwd, edgeBwd, factor_select_switch, direction_swap_switch,
                          filter_enable_jumper, configNeeded, pickupFault, flowOverload};
            syncB_reg <= syncA_reg;
        end
    end

    // Named views of the synchronised inputs.
    wire       sFwd     = syncB_reg[10];
    wire       sBwd     = syncB_reg[9];
    wire [3:0] sCode    = syncB_reg[8:5];
    wire       sSwap    = syncB_reg[4];
    wire       sFilter  = syncB_reg[3];
    wire       sConfig  = syncB_reg[2];
    wire       sPickup  = syncB_reg[1];
    wire       sOverld  = syncB_reg[0];

    // The defect input is synchronised on its own pair and latched for good.
    logic defA_reg;
    logic defB_reg;
    logic defect_reg;

    // The defect latch never clears except by reset.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            defA_reg   <= 1'b0;
            defB_reg   <= 1'b0;
            defect_reg <= 1'b0;
        end else begin
            defA_reg   <= componentDefect;
            defB_reg   <= defA_reg;
            defect_reg <= defect_reg | defB_reg;
        end
    end

    // Rising edges of the rotor pulses, one cycle each.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fwdPrev_reg <= 1'b0;
            bwdPrev_reg <= 1'b0;
        end else begin
            fwdPrev_reg <= sFwd;
            bwdPrev_reg <= sBwd;
        end
    end
    wire fwdEvt = sFwd & ~fwdPrev_reg;
    wire bwdEvt = sBwd & ~bwdPrev_reg;
    // Net change this cycle: both edges together cancel.
    wire evtUp   = fwdEvt & ~bwdEvt;
    wire evtDown = bwdEvt & ~fwdEvt;

    // Factor decode, applied as soon as the switch settles in sync.
    wire [7:0] factor   = factor_of(sCode);
    wire       noFactor = (sCode > `FACTOR_LAST_CODE);
    // Half a turn in edges: 26 pole pairs times factor.
    wire [BAL_W-1:0] halfTurn = BAL_W'(`POLE_PAIRS * 32'(factor));
    // Outputs are allowed only without blocking conditions.
    wire outAllowed = ~sConfig & ~defect_reg & ~noFactor;

    // Signed balance of held-back edges and the net released pulses owed.
    logic signed [BAL_W-1:0] bal_reg;
    logic signed [BAL_W-1:0] bal_next;
    logic        [BAL_W-1:0] owe_reg;
    logic        [BAL_W-1:0] owe_next;
    logic                    oweFwd_reg;
    logic                    oweFwd_next;
    logic                    pref_reg;
    logic                    pref_next;
    logic                    stepNow;
    flow_pulse_pkg::out_state_t st_reg;
    flow_pulse_pkg::out_state_t st_next;

    // Running balance after this cycle's edge.
    wire signed [BAL_W-1:0] balStep = bal_reg + (evtUp ? BAL_W'(1) : (evtDown ? -BAL_W'(1) : BAL_W'(0)));
    wire signed [BAL_W-1:0] halfS   = $signed(halfTurn);
    // Magnitude beyond half a turn triggers release.
    wire overFwd = balStep >  halfS;
    wire overBwd = balStep < -halfS;
    // Owed steps left once this cycle's step is taken, so a cancelling edge never wraps the count.
    wire [BAL_W-1:0] oweLeft = stepNow ? owe_reg - BAL_W'(1) : owe_reg;

    // Filter and release decisions.
    always_comb begin
        bal_next    = bal_reg;
        owe_next    = oweLeft;
        oweFwd_next = oweFwd_reg;
        pref_next   = pref_reg;
        if (!sFilter) begin
            // Unfiltered: every edge adds one owed step directly or cancels an owed step of the other direction.
            bal_next = '0;
            if (evtUp || evtDown) begin
                if (oweLeft == '0 || oweFwd_reg == evtUp) begin
                    owe_next    = oweLeft + BAL_W'(1);
                    oweFwd_next = evtUp;
                end else begin
                    owe_next = oweLeft - BAL_W'(1);
                end
            end
        end else if (owe_reg != '0) begin
            // A released burst still drains; new edges keep adding to the balance.
            bal_next = balStep;
        end else if (overFwd || overBwd) begin
            // Net motion beyond half a turn is released with its direction.
            owe_next    = overFwd ? $unsigned(balStep) : $unsigned(-balStep);
            oweFwd_next = overFwd;
            pref_next   = overFwd;
            bal_next    = '0;
        end else begin
            // Opposite edges cancel while within half a turn.
            bal_next = balStep;
        end
    end

    // Output sequencer: a step then a gap cycle, so each edge is seen.
    // A step fires only while something is still owed; a cancelled debt skips it.
    assign stepNow = (st_reg == flow_pulse_pkg::OUT_STEP) && (owe_reg != '0);
    always_comb begin
        st_next = st_reg;
        unique case (st_reg)
            flow_pulse_pkg::OUT_IDLE: begin
                if (owe_reg != '0 && outAllowed) begin
                    st_next = flow_pulse_pkg::OUT_STEP;
                end
            end
            flow_pulse_pkg::OUT_STEP: st_next = flow_pulse_pkg::OUT_GAP;
            flow_pulse_pkg::OUT_GAP:  st_next = flow_pulse_pkg::OUT_IDLE;
            default:                  st_next = flow_pulse_pkg::OUT_IDLE;
        endcase
    end

    // State registers of the filter and sequencer.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            bal_reg    <= '0;
            owe_reg    <= '0;
            oweFwd_reg <= 1'b1;
            pref_reg   <= `PREF_DIR_RESET;
            st_reg     <= flow_pulse_pkg::OUT_IDLE;
        end else begin
            bal_reg    <= bal_next;
            owe_reg    <= owe_next;
            oweFwd_reg <= oweFwd_next;
            pref_reg   <= pref_next;
            st_reg     <= st_next;
        end
    end

    // Quadrature pair, walked one quarter per released step.
    logic qA;
    logic qB;
    quad_phase_gen u_quad (
        .clk    (clk),
        .arst_n (arst_n),
        .stepReq(stepNow),
        .stepFwd(oweFwd_reg),
        .phaseA (qA),
        .phaseB (qB)
    );

    // Blink timer, about 2 Hz.
    logic [31:0] blinkCnt_reg;
    logic        blink_reg;
    wire         blinkWrap = (blinkCnt_reg == 32'(BLINK_CYC - 1));
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            blinkCnt_reg <= 32'h0;
            blink_reg    <= 1'b0;
        end else begin
            blinkCnt_reg <= blinkWrap ? 32'h0 : blinkCnt_reg + 32'h1;
            blink_reg    <= blinkWrap ? ~blink_reg : blink_reg;
        end
    end

    // Lamp decode in priority: defect, configuration, alarm, no factor, normal.
    wire alarm    = sPickup | sOverld;
    wire greenNxt = defect_reg ? blink_reg : (sConfig ? 1'b1 : (noFactor ? blink_reg : 1'b1));
    wire yelNxt   = defect_reg ? blink_reg : sConfig;
    wire redNxt   = defect_reg ? blink_reg : (sConfig | alarm);
    // Swap exchanges phases and inverts the direction level.
    wire dirNxt   = oweFwd_reg ^ sSwap;

    // Registered outputs.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            channelA          <= 1'b0;
            channelB          <= 1'b0;
            channelEnable     <= 1'b0;
            flow_sense_output <= 1'b1;
            pulse_active_lamp <= 1'b0;
            lampYellow        <= 1'b0;
            lampRed           <= 1'b0;
            pulse_multiplier_setting <= 8'h00;
            preferredDir      <= `PREF_DIR_RESET;
        end else begin
            channelA          <= sSwap ? qB : qA;
            channelB          <= sSwap ? qA : qB;
            channelEnable     <= outAllowed;
            flow_sense_output <= dirNxt;
            pulse_active_lamp <= greenNxt;
            lampYellow        <= yelNxt;
            lampRed           <= redNxt;
            pulse_multiplier_setting <= factor;
            preferredDir      <= pref_reg;
        end
    end

    // Helper: a step in the sequencer is followed two cycles later by a channel change.
    property p_step_moves;
        @(posedge clk) disable iff (!arst_n)
        stepNow |=> ##1 ((channelA != $past(channelA)) || (channelB != $past(channelB)));
    endproperty
    a_step_moves: assert property (p_step_moves) else $error("step not seen on outputs");

    property p_no_out_blocked;
        @(posedge clk) disable iff (!arst_n)
        (st_reg == flow_pulse_pkg::OUT_IDLE && !outAllowed) |=> !stepNow;
    endproperty
    a_no_out_blocked: assert property (p_no_out_blocked) else $error("output while blocked");

    property p_defect_sticky;
        @(posedge clk) disable iff (!arst_n)
        defect_reg |=> defect_reg ##1 !channelEnable;
    endproperty
    a_defect_sticky: assert property (p_defect_sticky) else $error("defect cleared");

    property p_hold_within;
        @(posedge clk) disable iff (!arst_n)
        (sFilter && owe_reg == '0 && !overFwd && !overBwd) |=> (owe_reg == '0);
    endproperty
    a_hold_within: assert property (p_hold_within) else $error("released within half turn");

    property p_release;
        @(posedge clk) disable iff (!arst_n)
        (sFilter && owe_reg == '0 && overFwd) |=> (oweFwd_reg && pref_reg && owe_reg != '0);
    endproperty
    a_release: assert property (p_release) else $error("release missing");

    property p_nofilter;
        @(posedge clk) disable iff (!arst_n)
        !sFilter |=> (bal_reg == '0);
    endproperty
    a_nofilter: assert property (p_nofilter) else $error("balance kept unfiltered");

    property p_normal_lamps;
        @(posedge clk) disable iff (!arst_n)
        (!defect_reg && !sConfig && !alarm && !noFactor) |=> (pulse_active_lamp && !lampYellow && !lampRed);
    endproperty
    a_normal_lamps: assert property (p_normal_lamps) else $error("normal lamps wrong");

    property p_alarm_red;
        @(posedge clk) disable iff (!arst_n)
        (!defect_reg && alarm) |=> lampRed;
    endproperty
    a_alarm_red: assert property (p_alarm_red) else $error("alarm not red");

    property p_factor;
        @(posedge clk) disable iff (!arst_n)
        (sCode == 4'h9) |=> (pulse_multiplier_setting == 8'h80);
    endproperty
    a_factor: assert property (p_factor) else $error("factor decode wrong");
endmodule

// ---- quad_counter_model.sv ----
// Downstream counter model that decodes the quadrature pair into a signed count.
// Assumes push-pull outputs sampled on the block's own clock.
`timescale 1ns/1ps
module quad_counter_model (
    input  wire logic         clk,
    input  wire logic         arst_n,
    input  wire logic         channelA,
    input  wire logic         channelB,
    input  wire logic         channelEnable,
    output logic signed [15:0] count
);
    logic prevA;  // Channel A seen on the last edge.
    logic prevB;  // Channel B seen on the last edge.
    wire  moved   = (channelA ^ prevA) ^ (channelB ^ prevB);  // Exactly one channel changed.
    wire  forward = prevB ^ channelA;                          // Forward order is 00,10,11,01.

    // Adds one step per single-channel change while channelEnable is high, signed by the phase order.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            prevA <= 1'b0;
            prevB <= 1'b0;
            count <= 16'sh0000;
        end else begin
            prevA <= channelA;
            prevB <= channelB;
            if (moved && channelEnable) begin
                count <= forward ? count + 16'sh0001 : count - 16'sh0001;
            end
        end
    end
endmodule

// ---- flow_pulse_output_control_tb.sv ----
// Self-checking bench of the flow pulse output control with a counter model.
// Assumes the design files and the constants header are compiled first.
`timescale 1ns/1ps
module flow_pulse_output_control_tb;
    logic        clk = 1'b0, arst_n = 1'b0, edgeFwd = 1'b0, edgeBwd = 1'b0;
    logic [3:0]  fsel = 4'h0;                 // Rotary code.
    logic        swap = 1'b0, filt = 1'b0, cfg = 1'b0, pick = 1'b0, ovl = 1'b0, dfct = 1'b0;
    logic        chA, chB, chEn, fsense, pref, green, yellow, red;
    logic [7:0]  factor;                      // Active factor seen at the outputs.
    logic signed [15:0] cnt;                  // Count held by the counter model.
    logic [15:0] c0;                          // Count at the start of a step.
    int          errors = 0, checked = 0, cycles = 0, nOn, nOff;
    logic [7:0]  facTab [16] = '{8'h01, 8'h02, 8'h05, 8'h0A, 8'h19, 8'h20, 8'h32, 8'h40,
                                 8'h64, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

    flow_pulse_output_control #(.BAL_W(16), .BLINK_CYC(4)) dut (
        .clk(clk), .arst_n(arst_n), .edgeFwd(edgeFwd), .edgeBwd(edgeBwd),
        .factor_select_switch(fsel), .direction_swap_switch(swap), .filter_enable_jumper(filt),
        .configNeeded(cfg), .pickupFault(pick), .flowOverload(ovl), .componentDefect(dfct),
        .channelA(chA), .channelB(chB), .channelEnable(chEn), .flow_sense_output(fsense),
        .preferredDir(pref), .pulse_multiplier_setting(factor), .pulse_active_lamp(green),
        .lampYellow(yellow), .lampRed(red));
    quad_counter_model partner (.clk(clk), .arst_n(arst_n), .channelA(chA), .channelB(chB),
        .channelEnable(chEn), .count(cnt));

    // Clock at 40 MHz.
    always #12.5 clk = ~clk;

    // Cuts a hang short once the run should long have ended.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            stop_test();
        end
    end

    // Prints the counts and the verdict, then ends the run.
    task stop_test();
        $display("Comparisons %0d, mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // Compares one value seen with its expectation.
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Waits a number of rising edges.
    task wt(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Sends rotor edges, each held high and low for three cycles.
    task pulse(input logic fwd, input int n);
        repeat (n) begin
            if (fwd) edgeFwd <= 1'b1;
            else edgeBwd <= 1'b1;
            wt(3);
            edgeFwd <= 1'b0;
            edgeBwd <= 1'b0;
            wt(3);
        end
    endtask

    // Counts blink phases of the green lamp over sixteen cycles.
    task blink(input logic allThree);
        nOn = 0;
        nOff = 0;
        repeat (16) begin
            @(negedge clk);
            if (green === 1'b1 && (!allThree || (yellow === 1'b1 && red === 1'b1))) nOn++;
            if (green === 1'b0 && (!allThree || (yellow === 1'b0 && red === 1'b0))) nOff++;
        end
    endtask

    // Unfiltered edges appear at once with their direction.
    task test_unfiltered();
        wt(1);
        c0 = cnt;
        pulse(1'b1, 5);
        wt(40);
        @(negedge clk);
        chk(cnt, c0 + 16'h0005);
        chk(fsense, 1'b1);
        chk({yellow, green, red}, 3'b010);
        wt(1);
        pulse(1'b0, 3);
        wt(40);
        @(negedge clk);
        chk(cnt, c0 + 16'h0002);
        chk(fsense, 1'b0);
        $display("Unfiltered test done");
    endtask

    // Every rotary code takes effect at once; blank codes blink green.
    task test_factors();
        for (int i = 0; i < 16; i++) begin
            wt(1);
            fsel <= 4'(i);
            wt(6);
            @(negedge clk);
            chk(factor, facTab[i]);
            if (i >= 10) begin
                chk(chEn, 1'b0);
                blink(1'b0);
                chk(nOn > 0 && nOff > 0, 1'b1);
            end
        end
        wt(1);
        fsel <= 4'h0;
        wt(6);
        $display("Factor test done");
    endtask

    // Oscillation is held until the net motion passes half a turn.
    task test_filter();
        wt(1);
        filt <= 1'b1;
        wt(6);
        c0 = cnt;
        pulse(1'b1, 20);
        pulse(1'b0, 10);
        pulse(1'b1, 16);
        wt(60);
        @(negedge clk);
        chk(cnt, c0);
        wt(1);
        pulse(1'b1, 1);
        wt(120);
        @(negedge clk);
        chk(cnt, c0 + 16'h001B);
        chk({pref, fsense}, 2'b11);
        wt(1);
        pulse(1'b0, 27);
        wt(120);
        @(negedge clk);
        chk(cnt, c0);
        chk({pref, fsense}, 2'b00);
        wt(1);
        fsel <= 4'h1;
        wt(6);
        pulse(1'b1, 52);
        wt(20);
        @(negedge clk);
        chk(cnt, c0);
        wt(1);
        pulse(1'b1, 1);
        wt(200);
        @(negedge clk);
        chk(cnt, c0 + 16'h0035);
        wt(1);
        fsel <= 4'h0;
        filt <= 1'b0;
        $display("Filter test done");
    endtask

    // The swap switch reverses the phase order and the direction level.
    task test_swap();
        wt(1);
        swap <= 1'b1;
        wt(6);
        c0 = cnt;
        pulse(1'b1, 3);
        wt(40);
        @(negedge clk);
        chk(cnt, c0 - 16'h0003);
        chk(fsense, 1'b0);
        wt(1);
        swap <= 1'b0;
        $display("Swap test done");
    endtask

    // Alarms light red; configuration lights all and holds the output.
    task test_alarms();
        wt(1);
        pick <= 1'b1;
        wt(6);
        @(negedge clk);
        chk(red, 1'b1);
        wt(1);
        pick <= 1'b0;
        ovl <= 1'b1;
        wt(6);
        @(negedge clk);
        chk(red, 1'b1);
        wt(1);
        ovl <= 1'b0;
        wt(6);
        @(negedge clk);
        chk(red, 1'b0);
        wt(1);
        cfg <= 1'b1;
        wt(6);
        @(negedge clk);
        chk({yellow, green, red, chEn}, 4'hE);
        c0 = cnt;
        wt(1);
        pulse(1'b1, 2);
        wt(30);
        @(negedge clk);
        chk(cnt, c0);
        wt(1);
        cfg <= 1'b0;
        wt(60);
        @(negedge clk);
        chk(cnt, c0 + 16'h0002);
        $display("Alarm test done");
    endtask

    // A component defect blinks all lamps and stops output for good.
    task test_defect();
        wt(1);
        dfct <= 1'b1;
        wt(2);
        dfct <= 1'b0;
        wt(6);
        @(negedge clk);
        chk(chEn, 1'b0);
        blink(1'b1);
        chk(nOn > 0 && nOff > 0, 1'b1);
        c0 = cnt;
        wt(1);
        pulse(1'b1, 2);
        wt(40);
        @(negedge clk);
        chk(cnt, c0);
        chk(chEn, 1'b0);
        $display("Defect test done");
    endtask

    // Main sequence: reset, then each scenario in turn.
    initial begin
        wt(4);
        @(negedge clk);
        chk({chA, chB, chEn, green, yellow, red, fsense, pref}, 8'h03);
        chk(factor, 8'h00);
        wt(1);
        arst_n <= 1'b1;
        wt(4);
        test_unfiltered();
        test_factors();
        test_filter();
        test_swap();
        test_alarms();
        test_defect();
        stop_test();
    end
endmodule
